// ### hw/blk_pkg.sv
// Purpose: shared constants for the command error / time block server
// Assumes: 16-bit block words, one word per transfer beat
// Notes:   block codes are decimal figures held as hex
package blk_pkg;
    localparam int unsigned WORD_W        = 16;
    localparam int unsigned RSP_W         = 17;
    localparam int unsigned IDX_W         = 10;
    localparam int unsigned FIFO_DEPTH    = 4;
    localparam int unsigned CMD_SLOTS     = 1000;
    localparam logic [9:0]  CMD_SLOTS_V   = 10'h3E8;
    localparam logic [15:0] ERR_BLK_CODE  = 16'h26DE;
    localparam logic [15:0] TIME_BLK_CODE = 16'h26F2;
    localparam logic [15:0] REPORT_MIN    = 16'h0001;
    localparam logic [15:0] REPORT_MAX    = 16'h00C8;
    // request word offsets
    localparam logic [7:0]  REQ_W0        = 8'h00;
    localparam logic [7:0]  REQ_W1        = 8'h01;
    localparam logic [7:0]  REQ_W2        = 8'h02;
    localparam logic [7:0]  RX_SAT        = 8'hFF;
    // error-table response word offsets
    localparam logic [7:0]  ERR_W_ZERO    = 8'h00;
    localparam logic [7:0]  ERR_W_NEXT    = 8'h01;
    localparam logic [7:0]  ERR_W_CNT     = 8'h02;
    localparam logic [7:0]  ERR_W_START   = 8'h03;
    localparam logic [7:0]  ERR_W_DATA    = 8'h04;
    localparam logic [7:0]  ERR_W_DEND    = 8'hCB;
    localparam logic [7:0]  ERR_W_ID      = 8'hF9;
    // time response word offsets
    localparam logic [7:0]  TIME_W_SEQ    = 8'h00;
    localparam logic [7:0]  TIME_W_ID     = 8'h01;
    localparam logic [7:0]  TIME_W_YEAR   = 8'h02;
    localparam logic [7:0]  TIME_W_MS     = 8'h08;
    localparam logic [7:0]  TIME_W_LAST   = 8'h3F;

    typedef enum logic [1:0] {IDLE, SEND_ERR, SEND_TIME} srv_state_t;
endpackage : blk_pkg

// ### hw/stream_if.sv
// Purpose: valid/ready word stream between the server and its fifo
// Assumes: single clock
// Notes:   data carries the word with a last flag in the top bit
`timescale 1ns/1ps
interface stream_if #(parameter int W = 17) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

// ### hw/rsp_fifo.sv
// Purpose: small response fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes:   frozen while i_en is low
`timescale 1ns/1ps
module rsp_fifo #(
    parameter int W = 17,
    parameter int D = 4
) (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_en,
    stream_if.snk     s_in,
    stream_if.src     s_out
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } fifo_st_t;

    fifo_st_t     st_ff;
    fifo_st_t     nxt_st;
    logic [W-1:0] mem_ff [D];
    logic         push;
    logic         pop;

    assign s_in.ready  = (st_ff.cnt != (AW+1)'(D));
    assign s_out.valid = (st_ff.cnt != '0);
    assign s_out.data  = mem_ff[st_ff.rp];
    assign push        = s_in.valid & s_in.ready & i_en;
    assign pop         = s_out.valid & s_out.ready & i_en;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wp = AW'(st_ff.wp + 1'b1);
        end
        if (pop) begin
            nxt_st.rp = AW'(st_ff.rp + 1'b1);
        end
        nxt_st.cnt = (AW+1)'(st_ff.cnt + push - pop);
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_ff[st_ff.wp] <= s_in.data;
        end
    end

    AST_FIFO_NO_OVERFLOW: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        st_ff.cnt <= (AW+1)'(D)) else $error("fifo count above depth");
endmodule : rsp_fifo

// ### hw/blk_server.sv
// Purpose: serves error-table and time request blocks from the host
// Assumes: request/response words arrive on the same clock as i_ref_clk
// Notes:   requests are refused (ready low) until the last response word is in the fifo
//
// Summary of operation
// R1: host puts error block code in word 0
// R2: host asks for 1 to 200 entries
// R3: host start index runs 0 to total minus 1
// R4: keep last error word per 1000 commands
// R5: valid error request gets error response block
// R6: word 0 zero, word 1 next block code
// R7: word 2 reports valid entries, 1 to 200
// R8: word 3 holds first reported command index
// R9: words 4 to 203 hold successive errors
// R10: words 204-248 unused, 249 holds code
// R11: host changes sequence word per time request
// R12: host time code in word 1, rest unused
// R13: changed sequence value per handled time request
// R14: time response carries time code word 1
// R15: word 2 holds four-digit year
// R16: word 3 holds month 1 to 12
// R17: word 4 holds day 1 to 31
// R18: word 5 holds hour 0 to 23
// R19: word 6 holds minute 0 to 59
// R20: word 7 holds seconds 0 to 59
// R21: word 8 milliseconds, words 9-63 unused
// R22: bad count or start gets no response
`timescale 1ns/1ps
module blk_server (
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_rst_b,
    input  wire logic                         i_clk_en,
    input  wire logic                         i_req_valid,
    input  wire logic                         i_req_first,
    input  wire logic                         i_req_last,
    input  wire logic [blk_pkg::WORD_W-1:0]   i_req_word,
    output logic                              o_req_ready,
    output logic                              o_rsp_valid,
    output logic [blk_pkg::WORD_W-1:0]        o_rsp_word,
    output logic                              o_rsp_last,
    input  wire logic                         i_rsp_ready,
    input  wire logic                         i_err_wr,
    input  wire logic [blk_pkg::IDX_W-1:0]    i_err_idx,
    input  wire logic [blk_pkg::WORD_W-1:0]   i_err_code,
    input  wire logic [blk_pkg::IDX_W-1:0]    i_configured_command_total,
    input  wire logic [blk_pkg::WORD_W-1:0]   i_next_blk,
    input  wire logic [6:0][blk_pkg::WORD_W-1:0] i_time_fields,
    output logic                              o_req_rej,
    output logic                              o_busy
);
    import blk_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        srv_state_t          state;
        logic [7:0]          rx_idx;
        logic [WORD_W-1:0]   w0;
        logic [WORD_W-1:0]   w1;
        logic [WORD_W-1:0]   w2;
        logic [7:0]          idx;
        logic [7:0]          cnt;
        logic [IDX_W-1:0]    start;
        logic [WORD_W-1:0]   nxt_blk;
        logic [WORD_W-1:0]   seq;
        logic [6:0][WORD_W-1:0] tm;
        logic                rej;
    } srv_st_t;

    srv_st_t             st_ff;
    srv_st_t             nxt_st;
    logic [1:0]          rst_sync_ff;
    logic                rst_b;
    logic [WORD_W-1:0]   err_mem [CMD_SLOTS];

    logic [7:0]          pos;
    logic [IDX_W-1:0]    tot;
    logic [IDX_W-1:0]    avail;
    logic [7:0]          ent_ofs;
    logic [IDX_W-1:0]    ent;
    logic                err_ok;
    logic                time_ok;
    logic [WORD_W-1:0]   word;
    logic                last;
    logic                push;

    stream_if #(.W(RSP_W)) f_in ();
    stream_if #(.W(RSP_W)) f_out ();

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_ff[1];

    // ----------------------------------------------------------------
    // last-error table
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_clk_en && i_err_wr && (i_err_idx < CMD_SLOTS_V)) begin
            err_mem[i_err_idx] <= i_err_code; // [R4]
        end
    end

    // ----------------------------------------------------------------
    // response word selection
    // ----------------------------------------------------------------
    assign ent_ofs = 8'(st_ff.idx - ERR_W_DATA);
    assign ent     = IDX_W'(st_ff.start + IDX_W'(ent_ofs));
    assign last    = (st_ff.state == SEND_ERR) ? (st_ff.idx == ERR_W_ID)
                                               : (st_ff.idx == TIME_W_LAST);

    always_comb begin
        word = '0;
        if (st_ff.state == SEND_ERR) begin
            if (st_ff.idx == ERR_W_ZERO) begin
                word = '0; // [R6]
            end else if (st_ff.idx == ERR_W_NEXT) begin
                word = st_ff.nxt_blk; // [R6]
            end else if (st_ff.idx == ERR_W_CNT) begin
                word = WORD_W'(st_ff.cnt); // [R7]
            end else if (st_ff.idx == ERR_W_START) begin
                word = WORD_W'(st_ff.start); // [R8]
            end else if (st_ff.idx == ERR_W_ID) begin
                word = ERR_BLK_CODE; // [R10]
            end else if ((st_ff.idx >= ERR_W_DATA) && (st_ff.idx <= ERR_W_DEND)
                         && (ent_ofs < st_ff.cnt)) begin
                word = err_mem[ent]; // [R9]
            end else begin
                word = '0; // [R10]
            end
        end else if (st_ff.state == SEND_TIME) begin
            if (st_ff.idx == TIME_W_SEQ) begin
                word = st_ff.seq; // [R13]
            end else if (st_ff.idx == TIME_W_ID) begin
                word = TIME_BLK_CODE; // [R14]
            end else if ((st_ff.idx >= TIME_W_YEAR) && (st_ff.idx <= TIME_W_MS)) begin
                // year, month, day, hour, minute, second, millisecond
                word = st_ff.tm[3'(st_ff.idx - TIME_W_YEAR)]; // [R15] [R16] [R17] [R18] [R19] [R20] [R21]
            end else begin
                word = '0; // [R21]
            end
        end
    end

    assign f_in.valid  = (st_ff.state != IDLE);
    assign f_in.data   = {last, word};
    assign push        = f_in.valid & f_in.ready & i_clk_en;

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    assign tot   = (i_configured_command_total > CMD_SLOTS_V) ? CMD_SLOTS_V
                                                              : i_configured_command_total;
    assign pos   = i_req_first ? REQ_W0 : st_ff.rx_idx;
    assign avail = IDX_W'(tot - st_ff.w2[IDX_W-1:0]);

    always_comb begin
        nxt_st     = st_ff;
        nxt_st.rej = 1'b0;
        err_ok     = 1'b0;
        time_ok    = 1'b0;
        unique case (st_ff.state)
            IDLE: begin
                if (i_req_valid) begin
                    if (pos == REQ_W0) begin
                        nxt_st.w0 = i_req_word;
                    end
                    if (pos == REQ_W1) begin
                        nxt_st.w1 = i_req_word;
                    end
                    if (pos == REQ_W2) begin
                        nxt_st.w2 = i_req_word;
                    end
                    if (pos != RX_SAT) begin
                        nxt_st.rx_idx = 8'(pos + 1'b1);
                    end
                    if (i_req_last) begin
                        err_ok = (nxt_st.w0 == ERR_BLK_CODE)
                                 && (nxt_st.w1 >= REPORT_MIN)
                                 && (nxt_st.w1 <= REPORT_MAX)
                                 && (nxt_st.w2 < WORD_W'(tot)); // [R22]
                        time_ok = !err_ok && (nxt_st.w1 == TIME_BLK_CODE);
                        nxt_st.idx = '0;
                        if (err_ok) begin
                            nxt_st.state   = SEND_ERR; // [R5]
                            nxt_st.start   = nxt_st.w2[IDX_W-1:0];
                            nxt_st.nxt_blk = i_next_blk;
                            // a range running past the list end is cut short
                            nxt_st.cnt     = (WORD_W'(tot - nxt_st.w2[IDX_W-1:0]) < nxt_st.w1)
                                             ? 8'(tot - nxt_st.w2[IDX_W-1:0])
                                             : nxt_st.w1[7:0]; // [R7]
                        end else if (time_ok) begin
                            nxt_st.state = SEND_TIME;
                            nxt_st.seq   = WORD_W'(st_ff.seq + 1'b1); // [R13]
                            nxt_st.tm    = i_time_fields;
                        end else begin
                            nxt_st.rej   = 1'b1; // [R22]
                        end
                    end
                end
            end
            SEND_ERR, SEND_TIME: begin
                if (f_in.ready) begin
                    nxt_st.idx = 8'(st_ff.idx + 1'b1);
                    if (last) begin
                        nxt_st.state = IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else if (i_clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // response fifo and outputs
    // ----------------------------------------------------------------
    rsp_fifo #(
        .W (RSP_W),
        .D (FIFO_DEPTH)
    ) u_rsp_fifo (
        .i_clk   (i_ref_clk),
        .i_rst_b (rst_b),
        .i_en    (i_clk_en),
        .s_in    (f_in),
        .s_out   (f_out)
    );

    assign f_out.ready = i_rsp_ready;
    assign o_rsp_valid = f_out.valid;
    assign o_rsp_word  = f_out.data[WORD_W-1:0];
    assign o_rsp_last  = f_out.data[WORD_W];
    assign o_req_ready = (st_ff.state == IDLE) & rst_b;
    assign o_req_rej   = st_ff.rej;
    assign o_busy      = (st_ff.state != IDLE);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_b);

    AST_BUSY_REFUSE: assert property ( // [R5]
        o_busy |-> !o_req_ready)
        else $error("request taken while busy");

    AST_ERR_W0_ZERO: assert property ( // [R6]
        push && st_ff.state == SEND_ERR && st_ff.idx == ERR_W_ZERO |-> word == '0)
        else $error("error block word 0 not zero");

    AST_ERR_W1_NEXT: assert property ( // [R6]
        push && st_ff.state == SEND_ERR && st_ff.idx == ERR_W_NEXT
        |-> word == st_ff.nxt_blk) else $error("error block word 1 wrong");

    AST_ERR_CNT_RANGE: assert property ( // [R7]
        push && st_ff.state == SEND_ERR && st_ff.idx == ERR_W_CNT
        |-> word >= REPORT_MIN && word <= REPORT_MAX) else $error("count out of range");

    AST_ERR_CNT_FIT: assert property ( // [R7]
        push && st_ff.state == SEND_ERR && st_ff.idx == ERR_W_CNT
        |-> WORD_W'(st_ff.start) + word <= WORD_W'(CMD_SLOTS_V))
        else $error("count runs past list end");

    AST_ERR_START: assert property ( // [R8]
        push && st_ff.state == SEND_ERR && st_ff.idx == ERR_W_START
        |-> word < WORD_W'(CMD_SLOTS_V)) else $error("start index out of range");

    AST_ERR_DATA: assert property ( // [R9]
        push && st_ff.state == SEND_ERR && st_ff.idx == ERR_W_DATA
        |-> word == err_mem[st_ff.start]) else $error("first entry not start index");

    AST_ERR_SPARE: assert property ( // [R10]
        push && st_ff.state == SEND_ERR && st_ff.idx > ERR_W_DEND && st_ff.idx < ERR_W_ID
        |-> word == '0) else $error("spare word not zero");

    AST_ERR_TAIL: assert property ( // [R10]
        push && st_ff.state == SEND_ERR && st_ff.idx == ERR_W_ID
        |-> word == ERR_BLK_CODE && last ##1 st_ff.state == IDLE)
        else $error("error block tail wrong");

    // ----------------------------------------------------------------
    // time block and refusal checks
    // ----------------------------------------------------------------
    AST_TIME_ID: assert property ( // [R14]
        push && st_ff.state == SEND_TIME && st_ff.idx == TIME_W_ID
        |-> word == TIME_BLK_CODE) else $error("time block code wrong");

    AST_TIME_MONTH: assert property ( // [R16]
        push && st_ff.state == SEND_TIME && st_ff.idx == 8'(TIME_W_YEAR + 8'h01)
        |-> word >= 16'h0001 && word <= 16'h000C) else $error("month out of range");

    AST_TIME_DAY: assert property ( // [R17]
        push && st_ff.state == SEND_TIME && st_ff.idx == 8'(TIME_W_YEAR + 8'h02)
        |-> word >= 16'h0001 && word <= 16'h001F) else $error("day out of range");

    AST_TIME_HOUR: assert property ( // [R18]
        push && st_ff.state == SEND_TIME && st_ff.idx == 8'(TIME_W_YEAR + 8'h03)
        |-> word <= 16'h0017) else $error("hour out of range");

    AST_TIME_MINUTE: assert property ( // [R19]
        push && st_ff.state == SEND_TIME && st_ff.idx == 8'(TIME_W_YEAR + 8'h04)
        |-> word <= 16'h003B) else $error("minute out of range");

    AST_TIME_SECOND: assert property ( // [R20]
        push && st_ff.state == SEND_TIME && st_ff.idx == 8'(TIME_W_YEAR + 8'h05)
        |-> word <= 16'h003B) else $error("second out of range");

    AST_TIME_MSEC: assert property ( // [R21]
        push && st_ff.state == SEND_TIME && st_ff.idx == TIME_W_MS
        |-> word <= 16'h03E7) else $error("millisecond out of range");

    AST_SEQ_CHANGE: assert property ( // [R13]
        i_clk_en && st_ff.state == IDLE && nxt_st.state == SEND_TIME
        |=> st_ff.seq == WORD_W'($past(st_ff.seq) + 1'b1)) else $error("sequence not changed");

    AST_BAD_NO_RSP: assert property ( // [R22]
        st_ff.rej |-> st_ff.state == IDLE && !f_in.valid) else $error("reply to bad request");

    AST_TIME_SPARE: assert property ( // [R21]
        push && st_ff.state == SEND_TIME && st_ff.idx > TIME_W_MS |-> word == '0)
        else $error("time spare word not zero");

    AST_TIME_TAIL: assert property ( // [R21]
        push && st_ff.state == SEND_TIME && st_ff.idx == TIME_W_LAST
        |-> last ##1 st_ff.state == IDLE) else $error("time block tail wrong");

    COV_ERR_BLOCK:  cover property (push && st_ff.state == SEND_ERR && last);
    COV_TIME_BLOCK: cover property (push && st_ff.state == SEND_TIME && last);
    COV_REJECT:     cover property (st_ff.rej);
    COV_STALL:      cover property (o_busy && !f_in.ready);
    COV_FROZEN:     cover property (o_busy && !i_clk_en);
endmodule : blk_server

// ### testbench/host_model.sv
// Purpose: host side model that sends request blocks and collects responses
// Assumes: requests are three words; responses end on the last flag
// Notes:   released data line shows the inverse of its last value
`timescale 1ns/1ps
module host_model (
    input  wire logic        i_clk,
    input  wire logic        i_stall,
    input  wire logic        i_req_ready,
    output logic             o_req_valid,
    output logic             o_req_first,
    output logic             o_req_last,
    output logic [15:0]      o_req_word,
    input  wire logic        i_rsp_valid,
    input  wire logic [15:0] i_rsp_word,
    input  wire logic        i_rsp_last,
    output logic             o_rsp_ready
);
    logic [15:0] rcv [0:255];
    int          rcv_n = 0;
    logic        done  = 1'b0;

    initial begin
        o_req_valid = 1'b0;
        o_req_first = 1'b0;
        o_req_last  = 1'b0;
        o_req_word  = 16'h0000;
        o_rsp_ready = 1'b0;
    end

    // --------------------------------------------------------------
    // response sink, stalls every other cycle when asked
    // --------------------------------------------------------------
    always @(posedge i_clk) begin
        if (i_rsp_valid === 1'b1 && o_rsp_ready === 1'b1 && rcv_n < 256) begin
            rcv[rcv_n] = i_rsp_word;
            rcv_n++;
            if (i_rsp_last === 1'b1) done = 1'b1;
        end
        #1 o_rsp_ready = i_stall ? ~o_rsp_ready : 1'b1;
    end

    // --------------------------------------------------------------
    // request driver: each word held until taken with ready high
    // --------------------------------------------------------------
    task send(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        logic [15:0] w [0:2];
        int          k;
        w[0]  = a;
        w[1]  = b;
        w[2]  = c;
        rcv_n = 0;
        done  = 1'b0;
        for (k = 0; k < 3; k++) begin
            #1;
            o_req_valid = 1'b1;
            o_req_first = (k == 0);
            o_req_last  = (k == 2);
            o_req_word  = w[k];
            do @(posedge i_clk); while (i_req_ready !== 1'b1);
        end
        #1;
        o_req_valid = 1'b0;
        o_req_first = 1'b0;
        o_req_last  = 1'b0;
        o_req_word  = ~o_req_word;
    endtask : send
endmodule : host_model

// ### testbench/blk_server_tb_top.sv
// Purpose: self-checking bench for the error table and time block server
// Assumes: host model drives the request side and sinks responses
// Notes:   error entries are written as 16'hE000 plus the command index
`timescale 1ns/1ps
module blk_server_tb_top;
    import blk_pkg::*;
    logic                   ref_clk = 1'b0;
    logic                   rst_b   = 1'b0;
    logic                   clk_en  = 1'b1;
    logic                   stall   = 1'b0;
    logic                   err_wr  = 1'b0;
    logic [IDX_W-1:0]       err_idx = 10'h000;
    logic [IDX_W-1:0]       cmd_tot = CMD_SLOTS_V;
    logic [WORD_W-1:0]      err_cd  = 16'h0000;
    logic [WORD_W-1:0]      nxt_blk = 16'h2710;
    logic [6:0][WORD_W-1:0] tfld    = {16'h03E7, 16'h003B, 16'h003B, 16'h0017,
                                       16'h001F, 16'h000C, 16'h07E9};
    logic                   rq_v, rq_f, rq_l, rq_rdy, rs_v, rs_l, rs_rdy, rej, busy;
    logic [15:0]            rq_w, rs_w;
    int                     errors      = 0;
    int                     check_count = 0;

    always #5 ref_clk = ~ref_clk;

    blk_server uut (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_clk_en(clk_en),
        .i_req_valid(rq_v), .i_req_first(rq_f), .i_req_last(rq_l), .i_req_word(rq_w),
        .o_req_ready(rq_rdy), .o_rsp_valid(rs_v), .o_rsp_word(rs_w), .o_rsp_last(rs_l),
        .i_rsp_ready(rs_rdy), .i_err_wr(err_wr), .i_err_idx(err_idx),
        .i_err_code(err_cd), .i_configured_command_total(cmd_tot),
        .i_next_blk(nxt_blk), .i_time_fields(tfld), .o_req_rej(rej), .o_busy(busy));

    host_model host (.i_clk(ref_clk), .i_stall(stall), .i_req_ready(rq_rdy),
        .o_req_valid(rq_v), .o_req_first(rq_f), .o_req_last(rq_l), .o_req_word(rq_w),
        .i_rsp_valid(rs_v), .i_rsp_word(rs_w), .i_rsp_last(rs_l), .o_rsp_ready(rs_rdy));

    // --------------------------------------------------------------
    // shared helpers
    // --------------------------------------------------------------
    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task wait_done();
        int k;
        for (k = 0; k < 3000 && host.done !== 1'b1; k++) @(posedge ref_clk);
        chk({15'h0000, host.done}, 16'h0001);
    endtask : wait_done

    task report_and_stop();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task err_case(input int cnt, input int start, input int tot);
        int          k;
        int          rep;
        logic [15:0] e;
        cmd_tot = tot[9:0];
        host.send(ERR_BLK_CODE, cnt[15:0], start[15:0]);
        chk({15'h0000, busy}, 16'h0001);
        chk({15'h0000, rq_rdy}, 16'h0000);
        wait_done();
        chk({15'h0000, busy}, 16'h0000);
        rep = (cnt < tot - start) ? cnt : tot - start;
        chk(host.rcv_n[15:0], 16'h00FA);
        chk(host.rcv[0], 16'h0000);
        chk(host.rcv[1], nxt_blk);
        chk(host.rcv[2], rep[15:0]);
        chk(host.rcv[3], start[15:0]);
        for (k = 4; k < 249; k++) begin
            e = (k - 4 < rep) ? 16'hE000 + 16'(start + k - 4) : 16'h0000;
            chk(host.rcv[k], e);
        end
        chk(host.rcv[249], ERR_BLK_CODE);
        $display("test error table cnt=%0d start=%0d done", cnt, start);
    endtask : err_case

    task bad_req(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        int seen;
        host.send(a, b, c);
        // the refusal pulse stands in the cycle right after the last word
        seen = (rej === 1'b1) ? 1 : 0;
        repeat (12) begin
            @(posedge ref_clk);
            #1;
            if (rej === 1'b1) seen++;
        end
        chk(seen[15:0], 16'h0001);
        chk(host.rcv_n[15:0], 16'h0000);
        $display("test refused request %h %h %h done", a, b, c);
    endtask : bad_req

    task time_case(input logic [15:0] seq, input logic [15:0] exp_seq);
        int k;
        host.send(seq, TIME_BLK_CODE, 16'h0000);
        // hold the clock enable low: nothing may leave while frozen
        clk_en = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        chk(host.rcv_n[15:0], 16'h0000);
        chk({15'h0000, busy}, 16'h0001);
        clk_en = 1'b1;
        wait_done();
        chk(host.rcv_n[15:0], 16'h0040);
        chk(host.rcv[0], exp_seq);
        chk(host.rcv[1], TIME_BLK_CODE);
        for (k = 0; k < 7; k++) chk(host.rcv[2 + k], tfld[k]);
        for (k = 9; k < 64; k++) chk(host.rcv[k], 16'h0000);
        $display("test time block seq=%h done", exp_seq);
    endtask : time_case

    // --------------------------------------------------------------
    // main sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        int i;
        repeat (20) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        for (i = 0; i < 1000; i++) begin
            err_wr  = 1'b1;
            err_idx = i[9:0];
            err_cd  = 16'hE000 + i[15:0];
            @(posedge ref_clk);
            #1;
        end
        err_wr = 1'b0;
        err_case(1, 0, 1000);
        stall = 1'b1;
        err_case(200, 0, 1000);
        stall = 1'b0;
        err_case(5, 998, 1000);
        err_case(5, 7, 10);
        bad_req(ERR_BLK_CODE, 16'h0000, 16'h0000);
        bad_req(ERR_BLK_CODE, 16'h00C9, 16'h0000);
        bad_req(ERR_BLK_CODE, 16'h0005, 16'h000A);
        bad_req(16'h1234, 16'h0005, 16'h0000);
        time_case(16'h0011, 16'h0001);
        stall = 1'b1;
        time_case(16'h0022, 16'h0002);
        report_and_stop();
    end

    initial begin
        #200_000;
        errors++;
        report_and_stop();
    end
endmodule : blk_server_tb_top
